// >>> hw/irq_priority_and_pwm_event_select.sv
/*
 * Holds the interrupt priority and waveform event selector: APB registers for the high
 * and low priority bits of seven sources, the paged waveform interrupt control, the
 * priority arbiter and a sticky event status with mask and one interrupt line.
 * Assumes an APB master on pclk, request inputs from the CPU interrupt sequencer that
 * are already pending and enabled, and waveform unit signals synchronous to pclk.
 */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_consts.svh"

// What this block does
// [R01] Read-write high priority bit per source
// [R02] Read-write low priority bit, same placement
// [R03] Level combines high and low bits
// [R04] Type 00 falling, 01 rising channel edge
// [R05] Type 10 centre, 11 end of period
// [R06] Software uses period types only center-aligned
// [R07] Channel pick 0..5, other codes channel 0
// [R08] Channel pick ignored for period types
// [R09] Shared index, page picks which register
// [R10] Reset clears all three registers
// [R11] Low priority register has bit set/clear
// [R12] Highest level presented first, higher preempts
// [R13] Bit 7 reads zero, ignores writes
module irq_priority_and_pwm_event_select
    import irq_prio_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`NUM_SRC-1:0] src_request,
    input wire logic service_active,
    input wire logic [1:0] service_level,
    input wire logic [`NUM_CH-1:0] waveform_ch_out,
    input wire logic waveform_center_point,
    input wire logic waveform_end_point,
    output logic grant_valid,
    output logic [2:0] grant_id,
    output logic [1:0] grant_level,
    output logic preempt_req,
    output logic waveform_irq,
    output logic irq
);

    // High priority bits, one per source.
    logic [7:0] prio_high_select;
    // Low priority bits, one per source.
    logic [7:0] prio_low_select;
    // Waveform interrupt type and channel pick.
    logic [7:0] waveform_irq_select;
    // Page selecting which register answers at the shared index.
    logic page;
    // Sticky event status and its mask.
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    // Bus answer state.
    bus_state_t bus_state;
    // Register index decoded from the address.
    logic [7:0] idx;
    // Address lies in the map.
    logic hit;
    // Read value of the addressed register.
    logic [7:0] rd_value;
    // Write commits at this edge.
    logic wr_commit;
    // Field views of the waveform control.
    logic [1:0] waveform_event_type;
    logic [2:0] waveform_channel_pick;
    // Event pulse from the picker.
    logic event_pulse;
    // Arbiter results.
    logic [`NUM_SRC-1:0] level_of_hi;
    logic next_grant_valid;
    src_id_t next_grant_id;
    level_t next_grant_level;
    logic best_found;
    logic next_preempt;
    // Status after set and clear.
    logic [1:0] next_status;

    assign waveform_event_type = waveform_irq_select[`WIRQ_TYPE_MSB:`WIRQ_TYPE_LSB];
    assign waveform_channel_pick = waveform_irq_select[`WIRQ_SEL_MSB:`WIRQ_SEL_LSB];
    assign level_of_hi = prio_high_select[`NUM_SRC-1:0];
    assign idx = paddr[9:2];

    // Decode the address; paddr[1:0] is ignored, so any address inside the map hits, aligned or not.
    always_comb
    begin
        hit = 1'b0;
        rd_value = 8'h00;
        if (paddr[11:10] != 2'h0)
        begin
            hit = 1'b0;
        end
        else if (idx == `IDX_PRIO_HIGH && page == `PAGE_PRIO)
        begin
            hit = 1'b1;
            rd_value = prio_high_select; // [R09]
        end
        else if (idx == `IDX_PRIO_HIGH)
        begin
            hit = 1'b1;
            rd_value = waveform_irq_select; // [R09]
        end
        else if (idx == `IDX_PRIO_LOW || idx == `IDX_LOW_SET || idx == `IDX_LOW_CLR)
        begin
            hit = 1'b1;
            rd_value = prio_low_select;
        end
        else if (idx == `IDX_PAGE)
        begin
            hit = 1'b1;
            rd_value = {7'h00, page};
        end
        else if (idx == `IDX_IRQ_STATUS)
        begin
            hit = 1'b1;
            rd_value = {6'h00, irq_status};
        end
        else if (idx == `IDX_IRQ_MASK)
        begin
            hit = 1'b1;
            rd_value = {6'h00, irq_mask};
        end
        else if (idx == `IDX_GRANT)
        begin
            hit = 1'b1;
            rd_value = {2'h0, grant_level, grant_id, grant_valid};
        end
    end

    // A write takes effect only at the edge where the master sees pready.
    assign wr_commit = ce && psel && penable && pwrite && (bus_state == BUS_ANSWER)
                       && pstrb[0] && hit;

    // APB answer: one wait state, then pready with data and error in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_state <= BUS_IDLE;
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            case (bus_state)
                BUS_IDLE:
                begin
                    // Answer in the cycle after the first access cycle.
                    if (psel && penable)
                    begin
                        bus_state <= BUS_ANSWER;
                        pready <= 1'b1;
                        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_value};
                        pslverr <= ~hit;
                    end
                end
                BUS_ANSWER:
                begin
                    // The transfer ends at this edge.
                    bus_state <= BUS_IDLE;
                    pready <= 1'b0;
                    prdata <= 32'h0000_0000;
                    pslverr <= 1'b0;
                end
                default:
                begin
                    bus_state <= BUS_IDLE;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    // Page register steering the shared index.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            page <= `PAGE_PRIO;
        end
        else if (wr_commit && idx == `IDX_PAGE)
        begin
            page <= pwdata[0];
        end
    end

    // High priority register on page 0 of the shared index.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prio_high_select <= `REG_RESET; // [R10]
        end
        else if (wr_commit && idx == `IDX_PRIO_HIGH && page == `PAGE_PRIO)
        begin
            prio_high_select <= pwdata[7:0] & `REG_IMPL_MASK; // [R01] [R09] [R13]
        end
    end

    // Waveform interrupt control on page 1 of the shared index.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            waveform_irq_select <= `REG_RESET; // [R10]
        end
        else if (wr_commit && idx == `IDX_PRIO_HIGH && page == `PAGE_WAVE)
        begin
            waveform_irq_select <= pwdata[7:0] & `WIRQ_IMPL_MASK; // [R09] [R13]
        end
    end

    // Low priority register: whole byte, or set and clear of single bits.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prio_low_select <= `REG_RESET; // [R10]
        end
        else if (wr_commit && idx == `IDX_PRIO_LOW)
        begin
            prio_low_select <= pwdata[7:0] & `REG_IMPL_MASK; // [R02] [R13]
        end
        else if (wr_commit && idx == `IDX_LOW_SET)
        begin
            prio_low_select <= (prio_low_select | pwdata[7:0]) & `REG_IMPL_MASK; // [R11]
        end
        else if (wr_commit && idx == `IDX_LOW_CLR)
        begin
            prio_low_select <= prio_low_select & ~pwdata[7:0]; // [R11]
        end
    end

    // Waveform event picker.
    waveform_event_pick u_pick
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .ch_out(waveform_ch_out),
        .center_point(waveform_center_point),
        .end_point(waveform_end_point),
        .event_type(waveform_event_type),
        .channel_pick(waveform_channel_pick),
        .event_pulse(event_pulse)
    );

    // Arbiter: highest combined level wins; ties go to the lowest source number.
    always_comb
    begin
        next_grant_id = 3'h0;
        next_grant_level = 2'h0;
        best_found = 1'b0;
        for (int i = `NUM_SRC - 1; i >= 0; i--)
        begin
            if (src_request[i] &&
                (!best_found || {level_of_hi[i], prio_low_select[i]} >= next_grant_level))
            begin
                best_found = 1'b1;
                next_grant_id = src_id_t'(i);
                next_grant_level = {level_of_hi[i], prio_low_select[i]}; // [R03]
            end
        end
        // While a service runs, only a strictly higher level is offered.
        next_grant_valid = best_found &&
                           (!service_active || next_grant_level > service_level); // [R12]
        next_preempt = next_grant_valid && service_active; // [R12]
    end

    // Register the arbiter outputs.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            grant_valid <= 1'b0;
            grant_id <= 3'h0;
            grant_level <= 2'h0;
            preempt_req <= 1'b0;
        end
        else if (ce)
        begin
            grant_valid <= next_grant_valid; // [R12]
            grant_id <= next_grant_id;
            grant_level <= next_grant_level;
            preempt_req <= next_preempt;
        end
    end

    // Waveform interrupt pulse towards the CPU.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            waveform_irq <= 1'b0;
        end
        else if (ce)
        begin
            waveform_irq <= event_pulse; // [R04] [R05]
        end
    end

    // Sticky status: a new event wins over a write-one clear in the same cycle.
    always_comb
    begin
        next_status = irq_status;
        if (wr_commit && idx == `IDX_IRQ_STATUS)
        begin
            next_status = irq_status & ~pwdata[1:0];
        end
        next_status[`EVT_WAVE] = next_status[`EVT_WAVE] | event_pulse;
        next_status[`EVT_PREEMPT] = next_status[`EVT_PREEMPT] | (next_preempt & ~preempt_req);
    end

    // Status register update.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= `EVT_RESET;
        end
        else if (ce)
        begin
            irq_status <= next_status;
        end
    end

    // Mask register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask <= `EVT_RESET;
        end
        else if (wr_commit && idx == `IDX_IRQ_MASK)
        begin
            irq_mask <= pwdata[1:0];
        end
    end

    // Interrupt line follows the masked status one cycle later.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else if (ce)
        begin
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule : irq_priority_and_pwm_event_select

`default_nettype wire

// >>> hw/irq_prio_consts.svh
/*
 * Holds the address indices, field positions, reset values and widths of the interrupt
 * priority and waveform event selector.
 * Assumes inclusion by its bare name from the design files that need it.
 */
`ifndef IRQ_PRIO_CONSTS_SVH
`define IRQ_PRIO_CONSTS_SVH

// Register indices; the APB byte address is four times the index.
`define IDX_PRIO_HIGH 8'hb7
`define IDX_PRIO_LOW 8'hb8
`define IDX_PAGE 8'hc8
`define IDX_LOW_SET 8'hc9
`define IDX_LOW_CLR 8'hca
`define IDX_IRQ_STATUS 8'hcb
`define IDX_IRQ_MASK 8'hcc
`define IDX_GRANT 8'hcd

// Reset value of the three byte registers and the mask of implemented priority bits.
`define REG_RESET 8'h00
`define REG_IMPL_MASK 8'h7f

// Field positions inside the waveform interrupt control register.
`define WIRQ_TYPE_MSB 5
`define WIRQ_TYPE_LSB 4
`define WIRQ_SEL_MSB 2
`define WIRQ_SEL_LSB 0
`define WIRQ_IMPL_MASK 8'h37

// Page values for the shared index.
`define PAGE_PRIO 1'b0
`define PAGE_WAVE 1'b1

// Event status bits.
`define EVT_WAVE 0
`define EVT_PREEMPT 1
`define EVT_RESET 2'h0

// Source and channel counts.
`define NUM_SRC 7
`define NUM_CH 6
`define CH_LAST 3'h5
`define CH_DEFAULT 3'h0

`endif

// >>> hw/irq_prio_pkg.sv
/*
 * Holds the types shared by the interrupt priority block and its event picker.
 * Assumes nothing of its surroundings.
 */
package irq_prio_pkg;

    // Waveform interrupt event kinds.
    typedef enum logic [1:0]
    {
        EVT_FALL = 2'h0,
        EVT_RISE = 2'h1,
        EVT_CENTER = 2'h2,
        EVT_END = 2'h3
    } waveform_event_t;

    // APB answer state, one-hot.
    typedef enum logic [1:0]
    {
        BUS_IDLE = 2'h1,
        BUS_ANSWER = 2'h2
    } bus_state_t;

    // Combined priority level, 3 is highest.
    typedef logic [1:0] level_t;

    // Source number, 0 is external interrupt 0.
    typedef logic [2:0] src_id_t;

endpackage : irq_prio_pkg

// >>> hw/waveform_event_pick.sv
/*
 * Holds the waveform interrupt event picker: edge detection on one chosen channel or
 * passing of the period centre or end pulse.
 * Assumes channel outputs and period pulses synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_consts.svh"

module waveform_event_pick
    import irq_prio_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [`NUM_CH-1:0] ch_out,
    input wire logic center_point,
    input wire logic end_point,
    input wire logic [1:0] event_type,
    input wire logic [2:0] channel_pick,
    output logic event_pulse
);

    // Last sampled level of every channel; kept for all so a new pick never fakes an edge.
    logic [`NUM_CH-1:0] prev_ch;
    // Chosen channel after mapping unused codes to channel 0.
    logic [2:0] chosen;
    // Current and previous level of the chosen channel.
    logic now_level;
    logic was_level;
    // Event seen in this cycle.
    logic next_event;

    // Map the pick code; codes above the last channel fall back to channel 0.
    always_comb
    begin
        if (channel_pick > `CH_LAST)
        begin
            chosen = `CH_DEFAULT; // [R07]
        end
        else
        begin
            chosen = channel_pick; // [R07]
        end
        now_level = ch_out[chosen];
        was_level = prev_ch[chosen];
    end

    // Select the event; the channel pick only matters for the edge kinds.
    always_comb
    begin
        case (waveform_event_t'(event_type))
            EVT_FALL: next_event = was_level & ~now_level; // [R04] [R08]
            EVT_RISE: next_event = ~was_level & now_level; // [R04] [R08]
            EVT_CENTER: next_event = center_point; // [R05] [R08]
            EVT_END: next_event = end_point; // [R05] [R08]
            default: next_event = 1'b0;
        endcase
    end

    // Remember channel levels.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_ch <= '0;
        end
        else if (ce)
        begin
            prev_ch <= ch_out;
        end
    end

    // Register the event pulse.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            event_pulse <= 1'b0;
        end
        else if (ce)
        begin
            event_pulse <= next_event;
        end
    end

endmodule : waveform_event_pick

`default_nettype wire

// >>> dv/irq_prio_monitor.sv
/* Checker on the top ports of the priority block.
   Assumes it is bound to that module and that ce is held high. */
`timescale 1ns/1ps
`default_nettype none
module irq_prio_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [6:0] src_request,
    input wire logic service_active,
    input wire logic [1:0] service_level,
    input wire logic [5:0] waveform_ch_out,
    input wire logic waveform_center_point,
    input wire logic waveform_end_point,
    input wire logic grant_valid,
    input wire logic [2:0] grant_id,
    input wire logic [1:0] grant_level,
    input wire logic preempt_req,
    input wire logic waveform_irq
);
    logic [6:0] req_q; // Requests as the arbiter last sampled them.
    logic svc_q; // Service flag as last sampled.
    logic [1:0] lvl_q; // Service level as last sampled.

    // Keeps one cycle of arbiter inputs to line up with its registered answer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_q <= 7'h0;
            svc_q <= 1'b0;
            lvl_q <= 2'h0;
        end
        else
        begin
            req_q <= src_request;
            svc_q <= service_active;
            lvl_q <= service_level;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // First access cycle of a transfer that has not been answered yet.
    sequence s_first_access;
        psel && penable && !pready && ce;
    endsequence

    // A single-cycle answer.
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    chk_one_wait: assert property (s_first_access ##1 ce |-> s_answer)
        else $error("answer not after one wait state");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error flag outside answer cycle");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer cycle");
    chk_bit7_zero: assert property (prdata[31:7] == 25'h000_0000)
        else $error("unimplemented read bits set");
    chk_grant_cause: assert property (grant_valid |-> req_q[grant_id])
        else $error("grant to a source without request");
    chk_grant_idle: assert property (req_q == 7'h0 |-> !grant_valid)
        else $error("grant with no request");
    chk_grant_beats: assert property (grant_valid && svc_q |-> grant_level > lvl_q)
        else $error("grant not above level in service");
    chk_preempt_flag: assert property (preempt_req == (grant_valid && svc_q))
        else $error("preempt flag wrong");
    chk_wave_cause: assert property (waveform_irq |-> $past(waveform_center_point, 2)
        || $past(waveform_end_point, 2) || $past(waveform_ch_out, 2) != $past(waveform_ch_out, 3))
        else $error("waveform event without cause");
endmodule : irq_prio_monitor

bind irq_priority_and_pwm_event_select irq_prio_monitor i_mon (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .prdata, .pready, .pslverr, .src_request, .service_active,
    .service_level, .waveform_ch_out, .waveform_center_point, .waveform_end_point,
    .grant_valid, .grant_id, .grant_level, .preempt_req, .waveform_irq);
`default_nettype wire

// >>> dv/irq_prio_partner.sv
/* Model of the interrupt sequencer and the waveform unit.
   Assumes the bench calls its tasks just after a rising pclk edge. */
`timescale 1ns/1ps
`default_nettype none
module irq_prio_partner (
    input wire logic pclk,
    output var logic [6:0] src_request,
    output var logic service_active,
    output var logic [1:0] service_level,
    output var logic [5:0] ch_out,
    output var logic center_point,
    output var logic end_point
);
    logic center_aligned; // High while the waveform unit counts up and down.

    // Quiet state at time zero.
    initial
    begin
        {src_request, service_active, service_level} = 10'h000;
        {ch_out, center_point, end_point} = 8'h00;
        center_aligned = 1'b0;
    end

    // Presents pending requests and the level being served.
    task set_req(input logic [6:0] r, input logic [2:0] s);
        @(posedge pclk);
        src_request <= r;
        {service_active, service_level} <= s;
    endtask : set_req

    // Sets the channel outputs.
    task set_ch(input logic [5:0] v);
        @(posedge pclk);
        ch_out <= v;
    endtask : set_ch

    // One centre or end pulse; these exist only in center-aligned mode.
    task pulse(input logic at_end);
        @(posedge pclk);
        if (center_aligned)
        begin
            center_point <= !at_end;
            end_point <= at_end;
        end
        @(posedge pclk);
        center_point <= 1'b0;
        end_point <= 1'b0;
    endtask : pulse
endmodule : irq_prio_partner
`default_nettype wire

// >>> dv/testbench.sv
/* Self-checking bench for the priority block over APB.
   Assumes the design, its header and the partner model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [6:0] src_request;
    logic [5:0] waveform_ch_out;
    logic service_active, waveform_center_point, waveform_end_point;
    logic grant_valid, preempt_req, waveform_irq;
    logic [1:0] service_level, grant_level;
    logic [2:0] grant_id;
    logic [7:0] rv, msk; // Last read byte and compare mask.
    int num_errors, checks;
    int wcnt, w0; // Waveform interrupt pulses seen, and the count before one event.
    // Arbiter cases: high, low, requests, service, expected {pre,level,id,valid}.
    logic [39:0] arb [7] = '{40'h08_0109_0027, 40'h09_0109_0031, 40'h09_0009_0021,
        40'h08_4048_0027, 40'h08_0848_0700, 40'h08_0848_0677, 40'h00_0000_0000};
    // Waveform cases: type, pick, event kind, {channel, expected hit}.
    logic [15:0] wv [10] = '{16'h0001, 16'h0010, 16'h151b, 16'h1518, 16'h1611,
        16'h0701, 16'h2321, 16'h2306, 16'h3031, 16'h3020};

    irq_priority_and_pwm_event_select i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_request(src_request), .service_active(service_active),
        .service_level(service_level), .waveform_ch_out(waveform_ch_out),
        .waveform_center_point(waveform_center_point), .waveform_end_point(waveform_end_point),
        .grant_valid(grant_valid), .grant_id(grant_id), .grant_level(grant_level),
        .preempt_req(preempt_req), .waveform_irq(waveform_irq), .irq(irq));
    irq_prio_partner i_partner (.pclk(pclk), .src_request(src_request),
        .service_active(service_active), .service_level(service_level),
        .ch_out(waveform_ch_out), .center_point(waveform_center_point),
        .end_point(waveform_end_point));

    // 200 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Prints the verdict and ends the run.
    task stop_test;
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // One APB transfer; holds the request until pready is seen at an edge.
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n == 50) num_errors++;
        rv = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reads a register and compares it.
    task chk_reg(input string nm, input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        `CHK(nm, e, rv)
    endtask : chk_reg

    // Hang guard, far beyond the few hundred cycles the tests need.
    initial
    begin
        #100000;
        num_errors++;
        stop_test();
    end

    // Counts waveform interrupt pulses; an unknown level counts as a pulse too.
    always @(posedge pclk)
    begin
        if (presetn === 1'b1 && waveform_irq !== 1'b0) wcnt++;
    end

    // Main sequence.
    initial
    begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        num_errors = 0;
        checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk_reg("high reset", `IDX_PRIO_HIGH, 8'h00);
        chk_reg("low reset", `IDX_PRIO_LOW, 8'h00);
        apb(1'b1, `IDX_PAGE, 8'h01);
        chk_reg("wave reset", `IDX_PRIO_HIGH, 8'h00);
        apb(1'b1, `IDX_PRIO_HIGH, 8'hff);
        chk_reg("wave bits", `IDX_PRIO_HIGH, 8'h37);
        apb(1'b1, `IDX_PAGE, 8'h00);
        chk_reg("high page", `IDX_PRIO_HIGH, 8'h00);
        apb(1'b1, `IDX_PRIO_HIGH, 8'hff);
        chk_reg("high bits", `IDX_PRIO_HIGH, 8'h7f);
        apb(1'b1, `IDX_PRIO_LOW, 8'hd5);
        chk_reg("low bits", `IDX_PRIO_LOW, 8'h55);
        apb(1'b1, `IDX_LOW_SET, 8'h02);
        apb(1'b1, `IDX_LOW_CLR, 8'h11);
        chk_reg("low set clear", `IDX_PRIO_LOW, 8'h46);
        apb(1'b1, `IDX_PAGE, 8'h01);
        chk_reg("wave page", `IDX_PRIO_HIGH, 8'h37);
        apb(1'b0, 8'h10, 8'h00);
        `CHK("unmapped", 1'b1, er)
        apb(1'b1, `IDX_PAGE, 8'h00);
        // Levels come from both bits; ties go to the lowest source.
        foreach (arb[i])
        begin
            apb(1'b1, `IDX_PRIO_HIGH, arb[i][39:32]);
            apb(1'b1, `IDX_PRIO_LOW, arb[i][31:24]);
            i_partner.set_req(arb[i][22:16], arb[i][10:8]);
            repeat (3) @(posedge pclk);
            msk = arb[i][0] ? 8'h7f : 8'h41;
            rv = {1'b0, preempt_req, grant_level, grant_id, grant_valid} & msk;
            `CHK("grant", arb[i][7:0] & msk, rv)
            if (arb[i][0]) chk_reg("grant reg", `IDX_GRANT, arb[i][7:0] & 8'h3f);
        end
        chk_reg("preempt status", `IDX_IRQ_STATUS, 8'h02);
        apb(1'b1, `IDX_PAGE, 8'h01);
        i_partner.center_aligned = 1'b1;
        // Every event type, boundary and out-of-range channel picks.
        foreach (wv[i])
        begin
            apb(1'b1, `IDX_PRIO_HIGH, {2'b00, wv[i][13:12], 1'b0, wv[i][10:8]});
            i_partner.set_ch(wv[i][4] ? 6'h00 : 6'h3f);
            repeat (4) @(posedge pclk);
            apb(1'b1, `IDX_IRQ_STATUS, 8'h03);
            w0 = wcnt;
            if (wv[i][5])
                i_partner.pulse(wv[i][4]);
            else
                i_partner.set_ch(wv[i][4] ? 6'h01 << wv[i][3:1] : ~(6'h01 << wv[i][3:1]));
            repeat (4) @(posedge pclk);
            chk_reg("wave event", `IDX_IRQ_STATUS, {7'h00, wv[i][0]});
            `CHK("wave pulse", wv[i][0], wcnt - w0)
            `CHK("irq masked", 1'b0, irq)
        end
        apb(1'b1, `IDX_IRQ_MASK, 8'h01);
        apb(1'b1, `IDX_PRIO_HIGH, 8'h00);
        i_partner.set_ch(6'h3e);
        repeat (4) @(posedge pclk);
        `CHK("irq raised", 1'b1, irq)
        apb(1'b1, `IDX_IRQ_STATUS, 8'h01);
        apb(1'b1, `IDX_IRQ_MASK, 8'h01);
        `CHK("irq cleared", 1'b0, irq)
        stop_test();
    end
endmodule : testbench
`default_nettype wire
